// file: common/cnsn_pkg.sv
package cnsn_pkg;
    localparam int CLK_HZ       = 100_000_000;
    localparam int BLINK_MS     = 200;
    localparam int FLASH_OFF_MS = 1000;
    localparam int BLINK_CYC    = BLINK_MS * (CLK_HZ / 1000);
    localparam int FLASH_PHASES = (FLASH_OFF_MS / BLINK_MS) + 1;
    localparam int TICK_W       = 25;

    localparam logic [7:0] NODE_ID_DFLT  = 8'h7F;
    localparam logic [7:0] NODE_ID_LIMIT = 8'h80;
    localparam logic [7:0] RATE_CODE_MAX = 8'h07;
    localparam logic [9:0] TIMER_MAX     = 10'h258;

    localparam logic [7:0] ADR_SETUP   = 8'h00;
    localparam logic [7:0] ADR_TIMER   = 8'h04;
    localparam logic [7:0] ADR_MAPA_LO = 8'h08;
    localparam logic [7:0] ADR_MAPA_HI = 8'h0C;
    localparam logic [7:0] ADR_MAPB_LO = 8'h10;
    localparam logic [7:0] ADR_MAPB_HI = 8'h14;
    localparam logic [7:0] ADR_CTRL    = 8'h18;
    localparam logic [7:0] ADR_IRQ_ST  = 8'h1C;
    localparam logic [7:0] ADR_IRQ_MSK = 8'h20;
    localparam logic [7:0] ADR_STATUS  = 8'h24;

    localparam int SET_NODE_LSB = 0;
    localparam int SET_RATE_LSB = 8;
    localparam int SET_SRC_LSB  = 16;
    localparam int SET_MODE_LSB = 20;
    localparam int ST_RATE_LSB  = 8;
    localparam int ST_STATE_LSB = 12;

    localparam int IRQ_START = 0;
    localparam int IRQ_RESET = 1;
    localparam int IRQ_LINK  = 2;
    localparam int IRQ_DROP  = 3;

    localparam logic [7:0] NMT_START      = 8'h01;
    localparam logic [7:0] NMT_STOP       = 8'h02;
    localparam logic [7:0] NMT_PREOP      = 8'h80;
    localparam logic [7:0] NMT_RESET_NODE = 8'h81;
    localparam logic [7:0] NMT_RESET_COMM = 8'h82;

    localparam logic [15:0] RATE_KBPS [8] = '{16'h007D, 16'h0014, 16'h0032, 16'h007D,
                                              16'h00FA, 16'h01F4, 16'h0320, 16'h03E8};

    typedef enum logic [1:0] {
        ST_INIT  = 2'b00,
        ST_PREOP = 2'b01,
        ST_OPER  = 2'b11,
        ST_STOP  = 2'b10
    } cnsn_state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } cnsn_nmt_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cnsn_apb_s;

    typedef logic [3:0][15:0] cnsn_map_t;
endpackage : cnsn_pkg

// file: rtl/cnsn_node_setup.sv
// Summary of operation
// - Node id 0 or 128 and above becomes 127.
// - Bit-rate code 0..7 decodes per table; 8 and above means 1 Mbit/s.
// - Node id applies only after power reset or remote node reset.
// - Bit rate applies only after power reset, not on node reset.
// - Four 16-bit selectors per direction of third process-data object, default 0.
// - Those selectors apply only after power reset or remote node reset.
// - Error reaction mode setting 0..15, default 0.
// - Error reaction timer 0.0 to 60.0 s, default 0.0 s.
// - After restart the node enters pre-operational by itself.
// - Pre-operational: green blinks, red off or flashing.
// - Start command makes node operational with green steadily on.
// - Operational node lets master drive and monitor via process data.
// - Link-break detection off by default; needs heartbeat or guarding enabled.
// - Process data exchanged only while operational; ignored otherwise.
// - Blinking is 200 ms on, 200 ms off.
// - Single flash is 200 ms on, then 1 s off.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cnsn_node_setup
    import cnsn_pkg::*;
#(
    parameter int BLINK_CYCLES = BLINK_CYC
) (
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire cnsn_apb_s   apb_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire cnsn_nmt_s   nmt_in,
    input  wire logic        link_loss_in,
    input  wire logic        pdo_rx_valid_in,
    output logic             pdo_rx_accept_out,
    output logic             pdo_tx_enable_out,
    output logic [7:0]       node_id_out,
    output logic [15:0]      bit_rate_kbps_out,
    output logic             freq_cmd_from_net_out,
    output logic             run_cmd_from_net_out,
    output logic [3:0]       err_mode_out,
    output logic [9:0]       err_timer_out,
    output cnsn_map_t        map_a_out,
    output cnsn_map_t        map_b_out,
    output logic             heartbeat_en_out,
    output cnsn_state_e      nmt_state_out,
    output logic             green_state_indicator_out,
    output logic             red_fault_indicator_out,
    output logic             irq_out
);
    logic [7:0]  node_set_ff;
    logic [7:0]  rate_set_ff;
    logic [1:0]  src_ff;
    logic [3:0]  mode_ff;
    logic [9:0]  timer_ff;
    cnsn_map_t   map_a_ff;
    cnsn_map_t   map_b_ff;
    logic        guard_en_ff;
    logic [3:0]  irq_stat_ff;
    logic [3:0]  irq_mask_ff;
    logic [3:0]  nxt_irq_stat;
    logic [31:0] rdata_ff;
    logic        load_pwr_ff;
    logic        load_node_ff;
    logic [7:0]  node_id_ff;
    logic [15:0] kbps_ff;
    cnsn_map_t   act_a_ff;
    cnsn_map_t   act_b_ff;
    cnsn_state_e state_ff;
    cnsn_state_e nxt_state;
    logic        link_fault_ff;
    logic [TICK_W-1:0] tick_ff;
    logic [2:0]  phase_ff;
    logic        green_ff;
    logic        red_ff;
    logic        wr_en;
    logic        rd_setup;
    logic        mapped;
    logic        cmd_start;
    logic        cmd_reset_node;
    logic        drop_evt;
    logic        link_evt;
    logic        tick_wrap;
    logic        blink_on;
    logic        flash_on;

    // APB: zero wait states, read data captured during the setup cycle
    assign wr_en    = apb_in.psel & apb_in.penable & apb_in.pwrite;
    assign rd_setup = apb_in.psel & ~apb_in.penable & ~apb_in.pwrite;
    always_comb begin
        case (apb_in.paddr)
            ADR_SETUP, ADR_TIMER, ADR_MAPA_LO, ADR_MAPA_HI, ADR_MAPB_LO,
            ADR_MAPB_HI, ADR_CTRL, ADR_IRQ_ST, ADR_IRQ_MSK, ADR_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pready_out  = 1'b1;
    assign pslverr_out = apb_in.psel & apb_in.penable & ~mapped;
    assign prdata_out  = rdata_ff;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (apb_in.paddr)
                ADR_SETUP:   rdata_ff <= {8'h00, mode_ff, 2'b00, src_ff, rate_set_ff, node_set_ff};
                ADR_TIMER:   rdata_ff <= {22'h000000, timer_ff};
                ADR_MAPA_LO: rdata_ff <= {map_a_ff[1], map_a_ff[0]};
                ADR_MAPA_HI: rdata_ff <= {map_a_ff[3], map_a_ff[2]};
                ADR_MAPB_LO: rdata_ff <= {map_b_ff[1], map_b_ff[0]};
                ADR_MAPB_HI: rdata_ff <= {map_b_ff[3], map_b_ff[2]};
                ADR_CTRL:    rdata_ff <= {31'h00000000, guard_en_ff};
                ADR_IRQ_ST:  rdata_ff <= {28'h0000000, irq_stat_ff};
                ADR_IRQ_MSK: rdata_ff <= {28'h0000000, irq_mask_ff};
                ADR_STATUS:  rdata_ff <= {18'h00000, state_ff, 3'b000, link_fault_ff, node_id_ff};
                default:     rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Settings written by software; node id, bit rate and maps held until the next qualifying reset applies them, the rest take effect at once
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            node_set_ff <= 8'h00;
            rate_set_ff <= 8'h00;
            src_ff      <= 2'b00;
            mode_ff     <= 4'h0;
            timer_ff    <= 10'h000;
            map_a_ff    <= '0;
            map_b_ff    <= '0;
            guard_en_ff <= 1'b0;
            irq_mask_ff <= 4'h0;
        end else if (wr_en) begin
            case (apb_in.paddr)
                ADR_SETUP: begin
                    node_set_ff <= apb_in.pwdata[SET_NODE_LSB +: 8];
                    rate_set_ff <= apb_in.pwdata[SET_RATE_LSB +: 8];
                    src_ff      <= apb_in.pwdata[SET_SRC_LSB +: 2];
                    mode_ff     <= apb_in.pwdata[SET_MODE_LSB +: 4];
                end
                ADR_TIMER: begin
                    // Tenths of a second, saturated at the top of the range
                    timer_ff <= (apb_in.pwdata[31:0] > 32'(TIMER_MAX)) ? TIMER_MAX
                              : apb_in.pwdata[9:0];
                end
                ADR_MAPA_LO: map_a_ff[1:0] <= apb_in.pwdata;
                ADR_MAPA_HI: map_a_ff[3:2] <= apb_in.pwdata;
                ADR_MAPB_LO: map_b_ff[1:0] <= apb_in.pwdata;
                ADR_MAPB_HI: map_b_ff[3:2] <= apb_in.pwdata;
                ADR_CTRL:    guard_en_ff <= apb_in.pwdata[0];
                ADR_IRQ_MSK: irq_mask_ff <= apb_in.pwdata[3:0];
                default: begin
                end
            endcase
        end
    end

    assign freq_cmd_from_net_out = src_ff[0];
    assign run_cmd_from_net_out  = src_ff[1];
    assign err_mode_out          = mode_ff;
    assign err_timer_out         = timer_ff;
    assign heartbeat_en_out      = guard_en_ff;

    assign cmd_start      = nmt_in.valid & (nmt_in.code == NMT_START) & (state_ff != ST_INIT);
    assign cmd_reset_node = nmt_in.valid & (nmt_in.code == NMT_RESET_NODE);

    // Latch requests: power reset loads everything, node reset skips the bit rate
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            load_pwr_ff  <= 1'b1;
            load_node_ff <= 1'b1;
        end else begin
            load_pwr_ff  <= 1'b0;
            load_node_ff <= cmd_reset_node;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            node_id_ff <= NODE_ID_DFLT;
            act_a_ff   <= '0;
            act_b_ff   <= '0;
        end else if (load_node_ff) begin
            if (node_set_ff == 8'h00 || node_set_ff >= NODE_ID_LIMIT) begin
                node_id_ff <= NODE_ID_DFLT;
            end else begin
                node_id_ff <= node_set_ff;
            end
            act_a_ff <= map_a_ff;
            act_b_ff <= map_b_ff;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            kbps_ff <= RATE_KBPS[0];
        end else if (load_pwr_ff) begin
            kbps_ff <= RATE_KBPS[(rate_set_ff > RATE_CODE_MAX) ? 3'h7 : rate_set_ff[2:0]];
        end
    end

    assign node_id_out       = node_id_ff;
    assign bit_rate_kbps_out = kbps_ff;
    assign map_a_out         = act_a_ff;
    assign map_b_out         = act_b_ff;

    // Network state: no master command is needed to leave init
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_INIT: begin
                if (!load_node_ff) begin
                    nxt_state = ST_PREOP;
                end
            end
            ST_PREOP, ST_OPER, ST_STOP: begin
                if (nmt_in.valid) begin
                    case (nmt_in.code)
                        NMT_START:      nxt_state = ST_OPER;
                        NMT_STOP:       nxt_state = ST_STOP;
                        NMT_PREOP:      nxt_state = ST_PREOP;
                        NMT_RESET_NODE: nxt_state = ST_INIT;
                        NMT_RESET_COMM: nxt_state = ST_INIT;
                        default:        nxt_state = state_ff;
                    endcase
                end
            end
            default: nxt_state = ST_INIT;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_ff <= ST_INIT;
        end else begin
            state_ff <= nxt_state;
        end
    end
    assign nmt_state_out = state_ff;

    // Process data is passed only while operational
    assign pdo_rx_accept_out = pdo_rx_valid_in & (state_ff == ST_OPER);
    assign pdo_tx_enable_out = (state_ff == ST_OPER);
    assign drop_evt          = pdo_rx_valid_in & (state_ff != ST_OPER);

    // Loss reports are meaningless unless guarding or heartbeat was enabled
    assign link_evt = link_loss_in & guard_en_ff;
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            link_fault_ff <= 1'b0;
        end else if (link_evt) begin
            // A loss reported in the clearing cycle must not be lost
            link_fault_ff <= 1'b1;
        end else if (cmd_reset_node || cmd_start) begin
            link_fault_ff <= 1'b0;
        end
    end

    // Sticky events; a new event in the clearing cycle survives
    always_comb begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_en && apb_in.paddr == ADR_IRQ_ST) begin
            nxt_irq_stat = irq_stat_ff & ~apb_in.pwdata[3:0];
        end
        nxt_irq_stat[IRQ_START] = nxt_irq_stat[IRQ_START] | cmd_start;
        nxt_irq_stat[IRQ_RESET] = nxt_irq_stat[IRQ_RESET] | cmd_reset_node;
        nxt_irq_stat[IRQ_LINK]  = nxt_irq_stat[IRQ_LINK] | link_evt;
        nxt_irq_stat[IRQ_DROP]  = nxt_irq_stat[IRQ_DROP] | drop_evt;
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            irq_stat_ff <= 4'h0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end
    assign irq_out = |(irq_stat_ff & irq_mask_ff);

    // One 200 ms tick drives a six-phase wheel shared by both indicator patterns
    assign tick_wrap = (tick_ff == TICK_W'(BLINK_CYCLES - 1));
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            tick_ff  <= '0;
            phase_ff <= 3'h0;
        end else if (tick_wrap) begin
            tick_ff  <= '0;
            phase_ff <= (phase_ff == 3'(FLASH_PHASES - 1)) ? 3'h0 : phase_ff + 3'h1;
        end else begin
            tick_ff <= tick_ff + TICK_W'(1);
        end
    end

    assign blink_on = ~phase_ff[0];
    assign flash_on = (phase_ff == 3'h0);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            green_ff <= 1'b0;
            red_ff   <= 1'b0;
        end else begin
            case (state_ff)
                ST_PREOP: green_ff <= blink_on;
                ST_OPER:  green_ff <= 1'b1;
                ST_STOP:  green_ff <= flash_on;
                default:  green_ff <= 1'b0;
            endcase
            red_ff <= link_fault_ff & flash_on;
        end
    end
    assign green_state_indicator_out = green_ff;
    assign red_fault_indicator_out   = red_ff;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    sequence s_start_cmd;
        cmd_start && state_ff == ST_PREOP;
    endsequence
    sequence s_oper_lit;
        state_ff == ST_OPER ##1 green_ff;
    endsequence

    AST_NODE_RANGE: assert property (
        $rose(state_ff == ST_PREOP) |-> node_id_ff != 8'h00 && node_id_ff < NODE_ID_LIMIT)
        else $error("node id out of range");
    AST_RATE_HELD: assert property (
        !$past(load_pwr_ff) |-> $stable(kbps_ff))
        else $error("bit rate changed without power reset");
    AST_NODE_HELD: assert property (
        !$past(load_node_ff) |-> $stable(node_id_ff) && $stable(act_a_ff))
        else $error("node id or map changed without reset");
    AST_AUTO_PREOP: assert property (
        $past(reset_in) && !reset_in |-> ##[1:3] state_ff == ST_PREOP)
        else $error("no pre-operational after restart");
    AST_START_OPER: assert property (
        s_start_cmd |=> s_oper_lit)
        else $error("start did not give operational with green on");
    AST_PDO_GATE: assert property (
        pdo_rx_valid_in && state_ff != ST_OPER |-> !pdo_rx_accept_out ##1 irq_stat_ff[IRQ_DROP])
        else $error("process data passed outside operational");
    AST_GUARD_OFF: assert property (
        link_loss_in && !guard_en_ff && !link_fault_ff |=> !link_fault_ff)
        else $error("link break seen with detection disabled");
    AST_BLINK: assert property (
        state_ff == ST_PREOP && $past(state_ff) == ST_PREOP |-> green_ff == !$past(phase_ff[0]))
        else $error("pre-operational blink pattern wrong");
    AST_FLASH: assert property (
        state_ff == ST_STOP && $past(state_ff) == ST_STOP |-> green_ff == ($past(phase_ff) == 3'h0))
        else $error("single flash pattern wrong");
    AST_TIMER_MAX: assert property (
        timer_ff <= TIMER_MAX)
        else $error("error timer above 60 s");
endmodule : cnsn_node_setup
`default_nettype wire

// file: tb/cnsn_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module cnsn_master_model
    import cnsn_pkg::*;
(
    input  wire logic clock_in,
    input  wire logic pdo_accept_in,
    output cnsn_nmt_s nmt_out,
    output logic      pdo_valid_out,
    output logic      link_loss_out
);
    initial begin
        nmt_out = '0;
        pdo_valid_out = 1'b0;
        link_loss_out = 1'b0;
    end

    // Each command is driven with valid high for a single clock, then valid drops
    task automatic send_nmt(input logic [7:0] code);
        @(posedge clock_in);
        nmt_out <= '{valid: 1'b1, code: code};
        @(posedge clock_in);
        // Idle code line carries junk, so no stale command can be reused
        nmt_out <= '{valid: 1'b0, code: ~code};
    endtask : send_nmt

    task automatic send_pdo(output logic acc);
        @(posedge clock_in);
        pdo_valid_out <= 1'b1;
        @(posedge clock_in);
        acc = pdo_accept_in;
        pdo_valid_out <= 1'b0;
    endtask : send_pdo

    // A timeout is reported whether or not heartbeat is enabled; the node gates it with guard_en_ff
    task automatic drop_link();
        @(posedge clock_in);
        link_loss_out <= 1'b1;
        @(posedge clock_in);
        link_loss_out <= 1'b0;
    endtask : drop_link
endmodule : cnsn_master_model
`default_nettype wire

// file: tb/cnsn_node_setup_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cnsn_node_setup_tb_top
    import cnsn_pkg::*;
;
    logic        clock_in;
    logic        reset_in;
    cnsn_apb_s   apb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    cnsn_nmt_s   nmt;
    logic        link_loss;
    logic        pdo_valid;
    logic        pdo_accept;
    logic        pdo_tx_en;
    logic [7:0]  node_id;
    logic [15:0] kbps;
    logic        freq_net;
    logic        run_net;
    logic [3:0]  err_mode;
    logic [9:0]  err_timer;
    cnsn_map_t   map_a;
    cnsn_map_t   map_b;
    logic        hb_en;
    cnsn_state_e state;
    logic        green;
    logic        red;
    logic        irq;
    int          err_total;
    int          n_compared;
    logic [31:0] rd;
    logic        rerr;
    int          g_on;
    int          r_on;

    cnsn_node_setup #(.BLINK_CYCLES(4)) cnsn_node_setup_i (
        .clock_in(clock_in), .reset_in(reset_in), .apb_in(apb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .nmt_in(nmt), .link_loss_in(link_loss),
        .pdo_rx_valid_in(pdo_valid), .pdo_rx_accept_out(pdo_accept),
        .pdo_tx_enable_out(pdo_tx_en), .node_id_out(node_id), .bit_rate_kbps_out(kbps),
        .freq_cmd_from_net_out(freq_net), .run_cmd_from_net_out(run_net),
        .err_mode_out(err_mode), .err_timer_out(err_timer), .map_a_out(map_a),
        .map_b_out(map_b), .heartbeat_en_out(hb_en), .nmt_state_out(state),
        .green_state_indicator_out(green), .red_fault_indicator_out(red), .irq_out(irq));

    cnsn_master_model cnsn_master_model_i (
        .clock_in(clock_in), .pdo_accept_in(pdo_accept), .nmt_out(nmt),
        .pdo_valid_out(pdo_valid), .link_loss_out(link_loss));

    always #5 clock_in = ~clock_in;

    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : step

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock_in);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clock_in);
        apb.penable <= 1'b1;
        @(posedge clock_in);
        while (pready !== 1'b1) begin
            @(posedge clock_in);
        end
        rd = prdata;
        rerr = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        #1;
    endtask : apb_xfer

    task automatic count24();
        g_on = 0;
        r_on = 0;
        repeat (24) begin
            step(1);
            g_on += (green === 1'b1);
            r_on += (red === 1'b1);
        end
    endtask : count24

    task automatic reset_node();
        cnsn_master_model_i.send_nmt(NMT_RESET_NODE);
        step(4);
    endtask : reset_node

    task automatic t_defaults();
        chk(node_id, NODE_ID_DFLT);
        chk(kbps, 16'h007D);
        chk(state, ST_PREOP);
        chk({freq_net, run_net}, 2'h0);
        chk(map_a, 64'h0);
        chk(map_b, 64'h0);
        chk({err_mode, err_timer}, 14'h0);
        chk(hb_en, 1'b0);
        count24();
        chk(g_on, 12);
        chk(r_on, 0);
    endtask : t_defaults

    task automatic t_pdo_idle();
        logic acc;
        cnsn_master_model_i.send_pdo(acc);
        chk(acc, 1'b0);
        apb_xfer(1'b1, ADR_IRQ_MSK, 32'h0000_0000);
        apb_xfer(1'b0, ADR_IRQ_ST, 32'h0);
        chk(rd, 32'h0000_0008);
        apb_xfer(1'b1, ADR_IRQ_ST, 32'h0000_0008);
        apb_xfer(1'b0, ADR_IRQ_ST, 32'h0);
        chk(rd, 32'h0);
    endtask : t_pdo_idle

    task automatic t_config();
        apb_xfer(1'b1, ADR_SETUP, 32'h00F3_0405);
        apb_xfer(1'b1, ADR_MAPA_LO, 32'h2222_1111);
        apb_xfer(1'b1, ADR_MAPA_HI, 32'h4444_3333);
        apb_xfer(1'b1, ADR_MAPB_LO, 32'h6666_5555);
        apb_xfer(1'b1, ADR_MAPB_HI, 32'h8888_7777);
        apb_xfer(1'b1, ADR_TIMER, 32'h0000_03FF);
        apb_xfer(1'b0, ADR_TIMER, 32'h0);
        chk(rd, {22'h0, TIMER_MAX});
        chk(err_timer, TIMER_MAX);
        chk({freq_net, run_net, err_mode}, 6'h3F);
        chk(node_id, NODE_ID_DFLT);
        chk(map_a, 64'h0);
        reset_node();
        chk(node_id, 8'h05);
        chk(kbps, 16'h007D);
        chk(map_a, 64'h4444_3333_2222_1111);
        chk(map_b, 64'h8888_7777_6666_5555);
        chk(state, ST_PREOP);
    endtask : t_config

    task automatic t_node_limits();
        logic [7:0] set_v [5] = '{8'h00, 8'h80, 8'hFF, 8'h7F, 8'h01};
        logic [7:0] exp_v [5] = '{8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h01};
        for (int i = 0; i < 5; i++) begin
            apb_xfer(1'b1, ADR_SETUP, {24'h00F304, set_v[i]});
            reset_node();
            chk(node_id, exp_v[i]);
        end
    endtask : t_node_limits

    task automatic t_nmt();
        logic acc;
        apb_xfer(1'b1, ADR_IRQ_ST, 32'h0000_000F);
        cnsn_master_model_i.send_nmt(NMT_START);
        step(2);
        chk({state, pdo_tx_en}, {ST_OPER, 1'b1});
        count24();
        chk(g_on, 24);
        cnsn_master_model_i.send_pdo(acc);
        chk(acc, 1'b1);
        cnsn_master_model_i.send_nmt(NMT_STOP);
        cnsn_master_model_i.send_pdo(acc);
        chk({state, acc}, {ST_STOP, 1'b0});
        cnsn_master_model_i.send_nmt(8'h55);
        step(2);
        chk(state, ST_STOP);
        cnsn_master_model_i.send_nmt(NMT_PREOP);
        step(2);
        chk(state, ST_PREOP);
        cnsn_master_model_i.send_nmt(NMT_RESET_COMM);
        step(4);
        chk(state, ST_PREOP);
        cnsn_master_model_i.send_nmt(NMT_START);
        step(2);
        chk(state, ST_OPER);
    endtask : t_nmt

    task automatic t_link();
        apb_xfer(1'b1, ADR_CTRL, 32'h0);
        cnsn_master_model_i.drop_link();
        apb_xfer(1'b0, ADR_IRQ_ST, 32'h0);
        chk(rd[IRQ_LINK], 1'b0);
        apb_xfer(1'b1, ADR_CTRL, 32'h0000_0001);
        chk(hb_en, 1'b1);
        cnsn_master_model_i.drop_link();
        apb_xfer(1'b0, ADR_IRQ_ST, 32'h0);
        chk(rd[IRQ_LINK], 1'b1);
        count24();
        chk(r_on, 4);
        cnsn_master_model_i.send_nmt(NMT_START);
        count24();
        chk(r_on, 0);
    endtask : t_link

    task automatic t_irq_apb();
        apb_xfer(1'b1, ADR_IRQ_MSK, 32'h0);
        chk(irq, 1'b0);
        apb_xfer(1'b1, ADR_IRQ_MSK, 32'h0000_0001);
        chk(irq, 1'b1);
        apb_xfer(1'b1, ADR_IRQ_ST, 32'h0000_000F);
        apb_xfer(1'b0, ADR_IRQ_ST, 32'h0);
        chk({irq, rd}, 33'h0);
        apb_xfer(1'b0, 8'h28, 32'h0);
        chk({rerr, rd}, 33'h1_0000_0000);
        apb_xfer(1'b1, ADR_STATUS, 32'hFFFF_FFFF);
        apb_xfer(1'b0, ADR_STATUS, 32'h0);
        chk(rd, 32'h0000_3001);
    endtask : t_irq_apb

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        clock_in = 1'b0;
        reset_in = 1'b1;
        apb = '0;
        err_total = 0;
        n_compared = 0;
        repeat (8) @(posedge clock_in);
        reset_in <= 1'b0;
        step(3);
        t_defaults();
        t_pdo_idle();
        t_config();
        t_node_limits();
        t_nmt();
        t_link();
        t_irq_apb();
        test_done();
    end

    // Whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #200000;
        err_total++;
        test_done();
    end
endmodule : cnsn_node_setup_tb_top
`default_nettype wire
